/* logic/reg_sleep_fault_pkg.sv */
// Package with register map, field layout, reset values and types for the sleep and fault mask bank.
`default_nettype none
// What this block does
// - Sleep behaviour code 00 applies the image voltage while asleep, 01 turns the regulator off, 10 and 11 are reserved.
// - Sleep source code 00 takes the sleep register bit, 01 to 11 take low power lines one to three.
// - Image voltage codes run from 0.9V in 50mV steps to 1.65V at 01111, then from 1.8V in 100mV steps to 3.3V.
// - Image voltage resets to 11100 and both sleep fields reset to 00 from fixed defaults.
// - A mask bit at 1 blocks its source's fault from the active-low fault output, at 0 it lets it through.
// - Mask bit 15 covers the current-limit switch.
// - Mask bits 8 to 11 cover regulators one to four.
// - Mask bits 0 to 5 cover converters one to six.
// - All mask bits reset to 0.
// - Writes to the oscillator fuse-load bit take effect only while the security key is open.
// - The security key register must hold 0013h to open protected writes and resets to zero.
package reg_sleep_fault_pkg;
  localparam logic [7:0]  ADDR_SLEEP    = 8'hd3;
  localparam logic [7:0]  ADDR_MASK     = 8'hd7;
  localparam logic [7:0]  ADDR_BANDGAP  = 8'hd8;
  localparam logic [7:0]  ADDR_OSC      = 8'hd9;
  localparam logic [7:0]  ADDR_KEY      = 8'hdb;
  localparam logic [15:0] KEY_OPEN      = 16'h0013;
  localparam logic [15:0] KEY_RESET     = 16'h0000;
  localparam logic [4:0]  VIMG_RESET    = 5'h1c;
  localparam logic [1:0]  BEHAV_RESET   = 2'h0;
  localparam logic [1:0]  SRC_RESET     = 2'h0;
  localparam logic [15:0] MASK_RESET    = 16'h0000;
  localparam logic [15:0] MASK_USED     = 16'h8f3f;
  localparam int          FUSE_BIT      = 15;
  localparam int          LS_BIT        = 15;
  localparam int          BEHAV_LO      = 12;
  localparam int          SRC_LO        = 8;
  localparam int          VIMG_LO       = 0;
  localparam int          LDO_LO        = 8;
  localparam int          DC_LO         = 0;
  localparam logic [1:0]  BEHAV_IMAGE   = 2'h0;
  localparam logic [1:0]  BEHAV_OFF     = 2'h1;
  localparam logic [1:0]  SRC_REGBIT    = 2'h0;
  localparam logic [1:0]  SRC_LINE1     = 2'h1;
  localparam logic [1:0]  SRC_LINE2     = 2'h2;
  localparam logic [1:0]  SRC_LINE3     = 2'h3;

  // Register read or write request from the control interface.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Raw fault inputs grouped by source kind.
  typedef struct packed {
    logic       limit_switch;
    logic [3:0] regulator;
    logic [5:0] converter;
  } fault_in_t;

  // Regulator-4 sleep state as seen by the analog side.
  typedef enum logic [1:0] {
    REG4_NORMAL,
    REG4_IMAGE,
    REG4_OFF
  } reg4_state_t;
endpackage
`default_nettype wire

/* logic/reg_sleep_fault.sv */
// Register bank for regulator-4 sleep settings, supply fault masks and trim fuse load bits.
`default_nettype none
module reg_sleep_fault
  import reg_sleep_fault_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire reg_req_t    req_i,
  input  wire fault_in_t   fault_i,
  input  wire logic        sleep_reg_bit_i,
  input  wire logic        low_power_line_one_i,
  input  wire logic        low_power_line_two_i,
  input  wire logic        low_power_line_three_i,
  output var  logic [15:0] rdata_o,
  output var  logic        supply_fault_n_o,
  output var  reg4_state_t reg4_state_o,
  output var  logic [4:0]  regulator4_image_voltage_o,
  output var  logic        bandgap_fuse_load_o,
  output var  logic        oscillator_fuse_load_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Gives the image voltage in millivolts for a five-bit code.
  function automatic logic [11:0] image_mv(input logic [4:0] code);
    logic [11:0] mv;
    if (!code[4])
      mv = 12'(900 + 50 * int'(code[3:0]));
    else
      mv = 12'(1800 + 100 * int'(code[3:0]));
    return mv;
  endfunction

  // ----------------------------------------
  // Register state
  // ----------------------------------------

  logic [1:0]  regulator4_sleep_behaviour_reg;
  logic [1:0]  regulator4_sleep_behaviour_next;
  logic [1:0]  regulator4_sleep_source_reg;
  logic [1:0]  regulator4_sleep_source_next;
  logic [4:0]  regulator4_image_voltage_reg;
  logic [4:0]  regulator4_image_voltage_next;
  logic [15:0] mask_reg;
  logic [15:0] mask_next;
  logic        bandgap_fuse_load_reg;
  logic        bandgap_fuse_load_next;
  logic        oscillator_fuse_load_reg;
  logic        oscillator_fuse_load_next;
  logic [15:0] key_reg;
  logic [15:0] key_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        key_open;

  assign key_open = (key_reg == KEY_OPEN);

  // Computes register updates from writes and the read data from reads.
  always_comb
  begin
    regulator4_sleep_behaviour_next = regulator4_sleep_behaviour_reg;
    regulator4_sleep_source_next    = regulator4_sleep_source_reg;
    regulator4_image_voltage_next   = regulator4_image_voltage_reg;
    mask_next                       = mask_reg;
    bandgap_fuse_load_next          = bandgap_fuse_load_reg;
    oscillator_fuse_load_next       = oscillator_fuse_load_reg;
    key_next                        = key_reg;
    rdata_next                      = rdata_reg;
    if (req_i.wr)
    begin
      case (req_i.addr)
        ADDR_SLEEP:
        begin
          regulator4_sleep_behaviour_next = req_i.wdata[BEHAV_LO +: 2];
          regulator4_sleep_source_next    = req_i.wdata[SRC_LO +: 2];
          regulator4_image_voltage_next   = req_i.wdata[VIMG_LO +: 5];
        end
        ADDR_MASK:    mask_next = req_i.wdata & MASK_USED;
        ADDR_BANDGAP: bandgap_fuse_load_next = req_i.wdata[FUSE_BIT];
        ADDR_OSC:
        begin
          if (key_open)
            oscillator_fuse_load_next = req_i.wdata[FUSE_BIT];
        end
        ADDR_KEY:     key_next = req_i.wdata;
        default:      key_next = key_reg;
      endcase
    end
    if (req_i.rd)
    begin
      case (req_i.addr)
        ADDR_SLEEP:
        begin
          rdata_next = '0;
          rdata_next[BEHAV_LO +: 2] = regulator4_sleep_behaviour_reg;
          rdata_next[SRC_LO +: 2]   = regulator4_sleep_source_reg;
          rdata_next[VIMG_LO +: 5]  = regulator4_image_voltage_reg;
        end
        ADDR_MASK:    rdata_next = mask_reg;
        ADDR_BANDGAP: rdata_next = 16'(bandgap_fuse_load_reg) << FUSE_BIT;
        ADDR_OSC:     rdata_next = 16'(oscillator_fuse_load_reg) << FUSE_BIT;
        ADDR_KEY:     rdata_next = key_reg;
        default:      rdata_next = 16'h0000;
      endcase
    end
  end

  // Registers the bank; synchronous reset stands for the power state machine reset.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      regulator4_sleep_behaviour_reg <= BEHAV_RESET;
      regulator4_sleep_source_reg    <= SRC_RESET;
      regulator4_image_voltage_reg   <= VIMG_RESET;
      mask_reg                       <= MASK_RESET;
      bandgap_fuse_load_reg          <= 1'b0;
      oscillator_fuse_load_reg       <= 1'b0;
      key_reg                        <= KEY_RESET;
      rdata_reg                      <= 16'h0000;
    end
    else
    begin
      regulator4_sleep_behaviour_reg <= regulator4_sleep_behaviour_next;
      regulator4_sleep_source_reg    <= regulator4_sleep_source_next;
      regulator4_image_voltage_reg   <= regulator4_image_voltage_next;
      mask_reg                       <= mask_next;
      bandgap_fuse_load_reg          <= bandgap_fuse_load_next;
      oscillator_fuse_load_reg       <= oscillator_fuse_load_next;
      key_reg                        <= key_next;
      rdata_reg                      <= rdata_next;
    end
  end

  // ----------------------------------------
  // Sleep control and fault output
  // ----------------------------------------

  logic        sleep_active;
  reg4_state_t reg4_state_reg;
  reg4_state_t reg4_state_next;
  logic        fault_n_reg;
  logic        fault_n_next;
  logic [15:0] fault_vec;

  // Selects the sleep source and picks the regulator state.
  always_comb
  begin
    case (regulator4_sleep_source_reg)
      SRC_REGBIT: sleep_active = sleep_reg_bit_i;
      SRC_LINE1:  sleep_active = low_power_line_one_i;
      SRC_LINE2:  sleep_active = low_power_line_two_i;
      SRC_LINE3:  sleep_active = low_power_line_three_i;
      default:    sleep_active = 1'b0;
    endcase
    if (!sleep_active)
      reg4_state_next = REG4_NORMAL;
    else if (regulator4_sleep_behaviour_reg == BEHAV_OFF)
      reg4_state_next = REG4_OFF;
    else if (regulator4_sleep_behaviour_reg == BEHAV_IMAGE)
      reg4_state_next = REG4_IMAGE;
    else
      reg4_state_next = REG4_NORMAL;
  end

  // Places each fault at its mask bit and drives the active-low output.
  always_comb
  begin
    fault_vec                   = 16'h0000;
    fault_vec[LS_BIT]           = fault_i.limit_switch;
    fault_vec[LDO_LO +: 4]      = fault_i.regulator;
    fault_vec[DC_LO +: 6]       = fault_i.converter;
    fault_n_next = ~|(fault_vec & ~mask_reg);
  end

  // Registers the outputs of the control path.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      reg4_state_reg <= REG4_NORMAL;
      fault_n_reg    <= 1'b1;
    end
    else
    begin
      reg4_state_reg <= reg4_state_next;
      fault_n_reg    <= fault_n_next;
    end
  end

  assign rdata_o                    = rdata_reg;
  assign supply_fault_n_o           = fault_n_reg;
  assign reg4_state_o               = reg4_state_reg;
  assign regulator4_image_voltage_o = regulator4_image_voltage_reg;
  assign bandgap_fuse_load_o        = bandgap_fuse_load_reg;
  assign oscillator_fuse_load_o     = oscillator_fuse_load_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  logic [11:0] mv_check;
  assign mv_check = image_mv(regulator4_image_voltage_reg);

  property p_behav_off;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (sleep_active && regulator4_sleep_behaviour_reg == BEHAV_OFF) |=> (reg4_state_o == REG4_OFF);
  endproperty
  a_behav_off: assert property (p_behav_off) else $error("Sleep off behaviour not applied.");

  property p_src_line1;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (regulator4_sleep_source_reg == SRC_LINE1 && low_power_line_one_i
       && regulator4_sleep_behaviour_reg == BEHAV_IMAGE) |=> (reg4_state_o == REG4_IMAGE);
  endproperty
  a_src_line1: assert property (p_src_line1) else $error("Line one did not trigger sleep.");

  property p_vimg_range;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (regulator4_image_voltage_reg == 5'h0f) |-> (mv_check == 12'h672);
  endproperty
  a_vimg_range: assert property (p_vimg_range) else $error("Image voltage code map wrong.");

  property p_reset_vals;
    @(posedge mclk_i) !reset_n_i |=> (regulator4_image_voltage_o == VIMG_RESET && key_reg == KEY_RESET);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("Reset values wrong.");

  property p_mask_blocks;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (fault_i.limit_switch && mask_reg[LS_BIT] && (fault_i.regulator & ~mask_reg[LDO_LO +: 4]) == 4'h0
       && (fault_i.converter & ~mask_reg[DC_LO +: 6]) == 6'h00) |=> supply_fault_n_o;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("Masked fault reached the output.");

  property p_unmasked;
    @(posedge mclk_i) disable iff (!reset_n_i)
      ((fault_i.converter[0] && !mask_reg[DC_LO]) || (fault_i.regulator[3] && !mask_reg[LDO_LO + 3]))
      |=> !supply_fault_n_o;
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("Unmasked fault not shown.");

  property p_osc_locked;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_OSC && !key_open) |=> $stable(oscillator_fuse_load_o);
  endproperty
  a_osc_locked: assert property (p_osc_locked) else $error("Locked write changed osc fuse bit.");

  property p_wake;
    @(posedge mclk_i) disable iff (!reset_n_i)
      !sleep_active |=> (reg4_state_o == REG4_NORMAL);
  endproperty
  a_wake: assert property (p_wake) else $error("Regulator did not return to normal.");

  property p_image_state;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (sleep_active && regulator4_sleep_behaviour_reg == BEHAV_IMAGE) |=> (reg4_state_o == REG4_IMAGE);
  endproperty
  a_image_state: assert property (p_image_state) else $error("Sleep image behaviour not applied.");

  property p_reg_masked;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (fault_i.regulator != 4'h0 && (fault_i.regulator & ~mask_reg[LDO_LO +: 4]) == 4'h0
       && !fault_i.limit_switch && fault_i.converter == 6'h00) |=> supply_fault_n_o;
  endproperty
  a_reg_masked: assert property (p_reg_masked) else $error("Masked regulator fault reached the output.");

  property p_conv_masked;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (fault_i.converter != 6'h00 && (fault_i.converter & ~mask_reg[DC_LO +: 6]) == 6'h00
       && !fault_i.limit_switch && fault_i.regulator == 4'h0) |=> supply_fault_n_o;
  endproperty
  a_conv_masked: assert property (p_conv_masked) else $error("Masked converter fault reached the output.");

  property p_mask_reset;
    @(posedge mclk_i) !reset_n_i |=> (mask_reg == MASK_RESET && supply_fault_n_o);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("Fault masks not cleared by reset.");

  property p_osc_open;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_OSC && key_open)
      |=> (oscillator_fuse_load_o == $past(req_i.wdata[FUSE_BIT]));
  endproperty
  a_osc_open: assert property (p_osc_open) else $error("Open key did not pass osc fuse write.");

  property p_vimg_write;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_SLEEP)
      |=> (regulator4_image_voltage_o == $past(req_i.wdata[VIMG_LO +: 5]));
  endproperty
  a_vimg_write: assert property (p_vimg_write) else $error("Image voltage write not stored.");

  property p_bg_write;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_BANDGAP)
      |=> (bandgap_fuse_load_o == $past(req_i.wdata[FUSE_BIT]));
  endproperty
  a_bg_write: assert property (p_bg_write) else $error("Bandgap fuse write not stored.");

  c_sleep_off:  cover property (@(posedge mclk_i) reg4_state_o == REG4_OFF);
  c_sleep_img:  cover property (@(posedge mclk_i) reg4_state_o == REG4_IMAGE);
  c_fault:      cover property (@(posedge mclk_i) !supply_fault_n_o);
  c_osc_write:  cover property (@(posedge mclk_i) oscillator_fuse_load_o);

endmodule // reg_sleep_fault
`default_nettype wire

/* test/host_fault_monitor.sv */
// Host-side model that watches the active-low supply-fault line and counts fault events.
`default_nettype none
module host_fault_monitor (
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  input  wire logic       supply_fault_n_i,
  output var  logic [7:0] fault_events_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic line_reg;

  // Counts each high-to-low step of the line; the line is active low.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      line_reg       <= 1'b1;
      fault_events_o <= 8'h00;
    end
    else
    begin
      line_reg <= supply_fault_n_i;
      if (line_reg && !supply_fault_n_i)
        fault_events_o <= fault_events_o + 8'h01;
    end
  end
endmodule // host_fault_monitor
`default_nettype wire

/* test/tb_reg_sleep_fault.sv */
// Self-checking testbench for the regulator-4 sleep and supply-fault mask register bank.
`default_nettype none
module tb_reg_sleep_fault;
  import reg_sleep_fault_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals, rows and counters
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] mask;
    fault_in_t   flt;
    logic [15:0] cfg;
    logic [3:0]  src;   // Line three, two, one, register bit.
    logic        fault_n;
    reg4_state_t state;
  } row_t;

  localparam row_t ROWS [10] = '{
    '{16'h0000, 11'h400, 16'h001c, 4'h0, 1'b0, REG4_NORMAL},
    '{16'h8000, 11'h400, 16'h000f, 4'h1, 1'b1, REG4_IMAGE},
    '{16'h0200, 11'h040, 16'h1000, 4'h1, 1'b0, REG4_OFF},
    '{16'h0100, 11'h040, 16'h1100, 4'h2, 1'b1, REG4_OFF},
    '{16'h0f00, 11'h3c0, 16'h0210, 4'h4, 1'b1, REG4_IMAGE},
    '{16'h0020, 11'h020, 16'h0300, 4'h8, 1'b1, REG4_IMAGE},
    '{16'h003e, 11'h03f, 16'h0300, 4'h2, 1'b0, REG4_NORMAL},
    '{16'h8f3f, 11'h7ff, 16'h2000, 4'h1, 1'b1, REG4_NORMAL},
    '{16'hffff, 11'h7ff, 16'h3000, 4'hf, 1'b1, REG4_NORMAL},
    '{16'h0000, 11'h000, 16'h1000, 4'h0, 1'b1, REG4_NORMAL}};

  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  reg_req_t    req_i = '0;
  fault_in_t   fault_i = '0;
  logic        sleep_reg_bit_i = 1'b0;
  logic        low_power_line_one_i = 1'b0;
  logic        low_power_line_two_i = 1'b0;
  logic        low_power_line_three_i = 1'b0;
  logic [15:0] rdata_o;
  logic        supply_fault_n_o;
  reg4_state_t reg4_state_o;
  logic [4:0]  regulator4_image_voltage_o;
  logic        bandgap_fuse_load_o;
  logic        oscillator_fuse_load_o;
  logic [7:0]  fault_events;
  logic [7:0]  ev0;
  int          n_fail = 0;
  int          checks = 0;
  int          cycles = 0;

  always #4 mclk_i = ~mclk_i;

  reg_sleep_fault reg_sleep_fault_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req_i), .fault_i(fault_i),
    .sleep_reg_bit_i(sleep_reg_bit_i), .low_power_line_one_i(low_power_line_one_i),
    .low_power_line_two_i(low_power_line_two_i), .low_power_line_three_i(low_power_line_three_i),
    .rdata_o(rdata_o), .supply_fault_n_o(supply_fault_n_o), .reg4_state_o(reg4_state_o),
    .regulator4_image_voltage_o(regulator4_image_voltage_o), .bandgap_fuse_load_o(bandgap_fuse_load_o),
    .oscillator_fuse_load_o(oscillator_fuse_load_o));

  host_fault_monitor host_fault_monitor_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .supply_fault_n_i(supply_fault_n_o), .fault_events_o(fault_events));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Prints the verdict once and ends the run.
  task automatic test_done();
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Compares a plain value, zero-extended to 16 bits.
  task automatic chk_v(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compares the regulator-4 state output.
  task automatic chk_s(input reg4_state_t exp);
    checks++;
    if (reg4_state_o !== exp)
    begin
      n_fail++;
      $display("ERROR reg4_state expected %h seen %h", exp, reg4_state_o);
    end
  endtask

  // One-cycle write; the request is held over the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    req_i <= '{1'b1, 1'b0, a, d};
    @(posedge mclk_i);
    req_i <= '0;
  endtask

  // One-cycle read; data is looked at 1 ns after the taking edge.
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk_i);
    req_i <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge mclk_i);
    req_i <= '0;
    #1;
    chk_v($sformatf("rdata_%h", a), exp, rdata_o);
  endtask

  // Lets level outputs settle past their one-cycle latency.
  task automatic settle();
    repeat (3) @(posedge mclk_i);
    #1;
  endtask

  // Cuts a hang short.
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_fail++;
      test_done();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    settle();
    rd(ADDR_SLEEP, 16'h001c);
    rd(ADDR_MASK, 16'h0000);
    rd(ADDR_BANDGAP, 16'h0000);
    rd(ADDR_OSC, 16'h0000);
    rd(ADDR_KEY, 16'h0000);
    chk_v("vimg", 16'h001c, {11'h000, regulator4_image_voltage_o});
    chk_s(REG4_NORMAL);
    foreach (ROWS[i])
    begin
      @(posedge mclk_i);
      fault_i <= ROWS[i].flt;
      {low_power_line_three_i, low_power_line_two_i, low_power_line_one_i, sleep_reg_bit_i} <= ROWS[i].src;
      wr(ADDR_MASK, ROWS[i].mask);
      wr(ADDR_SLEEP, ROWS[i].cfg);
      settle();
      chk_v("fault_n", {15'h0000, ROWS[i].fault_n}, {15'h0000, supply_fault_n_o});
      chk_s(ROWS[i].state);
      chk_v("vimg", {11'h000, ROWS[i].cfg[4:0]}, {11'h000, regulator4_image_voltage_o});
      rd(ADDR_MASK, ROWS[i].mask & MASK_USED);
    end
    // Oscillator fuse bit is refused while the key is closed, then taken once it is open.
    wr(ADDR_OSC, 16'h8000);
    settle();
    chk_v("osc_fuse", 16'h0000, {15'h0000, oscillator_fuse_load_o});
    wr(ADDR_KEY, KEY_OPEN);
    rd(ADDR_KEY, 16'h0013);
    wr(ADDR_OSC, 16'h8000);
    settle();
    chk_v("osc_fuse", 16'h0001, {15'h0000, oscillator_fuse_load_o});
    wr(ADDR_KEY, 16'h0000);
    wr(ADDR_OSC, 16'h0000);
    settle();
    chk_v("osc_fuse", 16'h0001, {15'h0000, oscillator_fuse_load_o});
    // Bandgap fuse bit pulsed high then low, as software loads the trim.
    wr(ADDR_BANDGAP, 16'h8000);
    settle();
    chk_v("bg_fuse", 16'h0001, {15'h0000, bandgap_fuse_load_o});
    wr(ADDR_BANDGAP, 16'h0000);
    settle();
    chk_v("bg_fuse", 16'h0000, {15'h0000, bandgap_fuse_load_o});
    rd(8'hd4, 16'h0000);
    // Second reset in mid-run, then faults seen by the host model.
    wr(ADDR_MASK, 16'hffff);
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    settle();
    rd(ADDR_MASK, 16'h0000);
    rd(ADDR_KEY, 16'h0000);
    chk_v("osc_fuse", 16'h0000, {15'h0000, oscillator_fuse_load_o});
    ev0 = fault_events;
    @(posedge mclk_i);
    fault_i <= 11'h001;
    settle();
    chk_v("events", {8'h00, ev0 + 8'h01}, {8'h00, fault_events});
    wr(ADDR_MASK, 16'h0001);
    settle();
    chk_v("fault_n", 16'h0001, {15'h0000, supply_fault_n_o});
    @(posedge mclk_i);
    fault_i <= 11'h003;
    settle();
    chk_v("events", {8'h00, ev0 + 8'h02}, {8'h00, fault_events});
    test_done();
  end
endmodule // tb_reg_sleep_fault
`default_nettype wire
